// ==== test/spi_far_end.sv ====
/*
 * Behavioural far-side serial device: answers as a slave to the block's master
 * clock and can run as a master to clock the block in slave mode.
 * Assumes the bench's bus clock and the block's pin outputs are wired in.
 */
`timescale 1ns/1ps
`default_nettype none
module spi_far_end (
    input wire logic clk_i,
    input wire logic sclk_i,
    input wire logic mosi_i,
    input wire logic miso_i,
    input wire logic drive_i,
    output logic sclk_o,
    output logic mosi_o,
    output logic miso_o
);
    logic [7:0] shift_q = 8'h00;
    logic [7:0] got_q = 8'h00;
    logic [7:0] heard_q = 8'h00;
    logic last_q = 1'b0;
    initial begin
        sclk_o = 1'b0;
        mosi_o = 1'b0;
    end
    always @(posedge sclk_i) begin
        got_q <= {got_q[6:0], mosi_i};
    end
    always @(negedge sclk_i) begin
        last_q <= shift_q[7];
        shift_q <= {shift_q[6:0], ~shift_q[0]};
    end
    // Released line shows the inverse of its last bit, never a held value
    assign miso_o = drive_i ? shift_q[7] : ~last_q;
    // Half period of eight bus cycles keeps within the slave's sync limit
    task automatic xfer(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            mosi_o <= b[i];
            repeat (8) @(posedge clk_i);
            heard_q <= {heard_q[6:0], miso_i};
            sclk_o <= 1'b1;
            repeat (8) @(posedge clk_i);
            sclk_o <= 1'b0;
        end
        mosi_o <= ~b[0];
    endtask
endmodule
`default_nettype wire

// ==== test/tb.sv ====
/*
 * Self-checking bench for the serial port flag block: bus master tasks and
 * one task per scenario. Assumes the far-side model and a 200 MHz bus clock.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import spi_flags_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ss_n_q = 1'b1;
    ahb_req_type req_q;
    ahb_req_type bus;
    spi_pins_type pins;
    wire far_sclk, far_mosi, far_miso;
    logic [31:0] hrdata_o;
    logic hreadyout_o, hresp_o, sclk_o, sclk_oe_o, mosi_o, mosi_oe_o;
    logic miso_o, miso_oe_o, ss_gpio_free_o, irq_o;
    int fails = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [7:0] dv [4] = '{8'h02, 8'h08, 8'h20, 8'h80};
    always_comb begin
        bus = req_q;
        bus.hready = hreadyout_o;
    end
    assign pins = '{sclk: far_sclk, mosi: far_mosi, miso: far_miso, ss_n: ss_n_q};
    spi_flags u_spi_flags (.clk_i, .rst_n_i, .ahb_i(bus), .hrdata_o, .hreadyout_o,
        .hresp_o, .pins_i(pins), .sclk_o, .sclk_oe_o, .mosi_o, .mosi_oe_o, .miso_o,
        .miso_oe_o, .ss_gpio_free_o, .irq_o);
    spi_far_end u_spi_far_end (.clk_i, .sclk_i(sclk_o), .mosi_i(mosi_o), .miso_i(miso_o),
        .drive_i(sclk_oe_o), .sclk_o(far_sclk), .mosi_o(far_mosi), .miso_o(far_miso));
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    task final_report;
        if (fails == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            final_report;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Entered at a rising edge; holds each phase until hready is sampled high
    task bus_xfer(input logic wr, input logic [31:0] a, input logic [7:0] wd,
                  output logic [31:0] rd);
        req_q.hsel <= 1'b1;
        req_q.haddr <= a;
        req_q.htrans <= HTRANS_NONSEQ;
        req_q.hwrite <= wr;
        req_q.hsize <= 3'b010;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        req_q.hsel <= 1'b0;
        req_q.htrans <= 2'b00;
        req_q.hwdata <= {24'h0, wd};
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
    endtask
    task wr(input logic [31:0] a, input logic [7:0] d);
        logic [31:0] x;
        bus_xfer(1'b1, a, d, x);
    endtask
    task rdx(input logic [31:0] a, output logic [7:0] v);
        logic [31:0] x;
        bus_xfer(1'b0, a, 8'h00, x);
        v = x[7:0];
    endtask
    task rd(input logic [31:0] a, input logic [7:0] e);
        logic [31:0] x;
        bus_xfer(1'b0, a, 8'h00, x);
        chk(x, {24'h0, e});
    endtask
    task wait_bit(input int b);
        logic [7:0] s;
        do rdx(STAT_ADDR, s); while (s[b] !== 1'b1);
    endtask
    task t_reset;
        chk(32'(ss_gpio_free_o), 1);
        chk(32'(irq_o), 0);
        chk(32'(hresp_o), 0);
        rd(CTRL_ADDR, 8'h20);
        rd(STAT_ADDR, 8'h08);
        wr(32'h0000_0100, 8'hff);
        rd(32'h0000_0100, 8'h00);
    endtask
    task t_regs;
        wr(STAT_ADDR, 8'hff);
        rd(STAT_ADDR, 8'h4f);
        wr(STAT_ADDR, 8'h00);
        wr(CTRL_ADDR, 8'h21);
        tick(2);
        chk(32'(irq_o), 1);
        wr(CTRL_ADDR, 8'h20);
    endtask
    task t_master;
        int n;
        wr(CTRL_ADDR, 8'h22);
        for (int c = 0; c < 4; c++) begin
            u_spi_far_end.shift_q = 8'h3c + 8'(c);
            wr(STAT_ADDR, 8'(c));
            wr(DATA_ADDR, 8'ha5 ^ 8'(c));
            tick(2);
            chk(32'(mosi_oe_o), 1);
            rd(STAT_ADDR, 8'h08 | 8'(c));
            @(posedge sclk_o);
            n = 0;
            @(negedge clk_i);
            while (sclk_o === 1'b1) begin
                n++;
                @(negedge clk_i);
            end
            @(posedge clk_i);
            chk(32'(n), {24'h0, dv[c]});
            wait_bit(7);
            rd(STAT_ADDR, 8'h88 | 8'(c));
            wr(CTRL_ADDR, 8'ha2);
            tick(2);
            chk(32'(irq_o), 1);
            rd(DATA_ADDR, 8'h3c + 8'(c));
            chk(32'(u_spi_far_end.got_q), 32'(8'ha5 ^ 8'(c)));
            rd(STAT_ADDR, 8'h08 | 8'(c));
            chk(32'(irq_o), 0);
            wr(CTRL_ADDR, 8'h22);
        end
    endtask
    task t_overrun;
        int n;
        wr(STAT_ADDR, 8'h40);
        u_spi_far_end.shift_q = 8'h11;
        wr(DATA_ADDR, 8'h01);
        wait_bit(7);
        u_spi_far_end.shift_q = 8'h22;
        wr(DATA_ADDR, 8'h02);
        n = 0;
        while (irq_o !== 1'b1 && n < 400) begin
            tick(1);
            n++;
        end
        chk(32'(irq_o), 1);
        wr(STAT_ADDR, 8'h00);
        tick(2);
        chk(32'(irq_o), 0);
        wr(STAT_ADDR, 8'h40);
        rd(DATA_ADDR, 8'h11);
        rd(STAT_ADDR, 8'h68);
        rd(DATA_ADDR, 8'h11);
        rd(STAT_ADDR, 8'h48);
        tick(2);
        chk(32'(irq_o), 0);
    endtask
    task t_fault;
        logic [7:0] s;
        ss_n_q <= 1'b0;
        tick(4);
        chk(32'(ss_gpio_free_o), 1);
        rd(STAT_ADDR, 8'h48);
        ss_n_q <= 1'b1;
        wr(STAT_ADDR, 8'h44);
        tick(2);
        chk(32'(ss_gpio_free_o), 0);
        ss_n_q <= 1'b0;
        tick(4);
        ss_n_q <= 1'b1;
        tick(4);
        chk(32'(irq_o), 1);
        wr(STAT_ADDR, 8'h40);
        rd(STAT_ADDR, 8'h58);
        wr(DATA_ADDR, 8'h00);
        rdx(STAT_ADDR, s);
        chk(32'(s[4]), 0);
        wait_bit(7);
        rdx(DATA_ADDR, s);
    endtask
    task t_disable;
        wr(STAT_ADDR, 8'h03);
        wr(DATA_ADDR, 8'h77);
        tick(100);
        wr(CTRL_ADDR, 8'h20);
        tick(2);
        chk({29'h0, mosi_oe_o, sclk_oe_o, sclk_o}, 0);
        rd(STAT_ADDR, 8'h0b);
    endtask
    task t_slave;
        logic [7:0] s;
        wr(CTRL_ADDR, 8'h02);
        wr(STAT_ADDR, 8'h04);
        tick(2);
        chk(32'(ss_gpio_free_o), 0);
        wr(DATA_ADDR, 8'hc3);
        tick(2);
        rd(STAT_ADDR, 8'h0c);
        ss_n_q <= 1'b0;
        tick(4);
        chk(32'(miso_oe_o), 1);
        fork
            u_spi_far_end.xfer(8'h96);
            begin
                tick(30);
                wr(DATA_ADDR, 8'h3c);
                rd(STAT_ADDR, 8'h04);
            end
        join
        wait_bit(7);
        rd(STAT_ADDR, 8'h8c);
        rd(DATA_ADDR, 8'h96);
        chk(32'(u_spi_far_end.heard_q), 32'h0000_00c3);
        fork
            u_spi_far_end.xfer(8'h00);
            begin
                tick(40);
                ss_n_q <= 1'b1;
            end
        join
        rdx(STAT_ADDR, s);
        chk(32'(s[4]), 1);
        chk(32'(miso_oe_o), 0);
    endtask
    initial begin
        req_q = '0;
        tick(6);
        rst_n_i <= 1'b1;
        t_reset;
        t_regs;
        t_master;
        t_overrun;
        t_fault;
        t_disable;
        t_slave;
        final_report;
    end
endmodule
`default_nettype wire

// ==== verilog/spi_flags.sv ====
/*
 * Serial port status flags, data buffers, baud divider and a compact byte shifter.
 * Assumes a single AHB-Lite master, pins already brought into this chip's pads,
 * and a bus clock that stands for the clock generator base output.
 */
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Completed byte sets receive-full, maybe interrupts
// - Any data read clears receive-full
// - Error enable gates overrun, fault interrupts
// - Unread buffer: overrun, keep old byte
// - Overrun clears: status read then data read
// - Slave select rising mid-transfer faults slave
// - Slave select low faults a master
// - Fault clears: status read then data write
// - Handoff to shifter sets transmit-empty
// - Idle: transmit-empty again within two cycles
// - Busy slave holds new byte until done
// - Reset sets transmit-empty, clears receive-full
// - Fault sets only when enabled; sticky
// - Select pin free when disabled or plain master
// - Detection off: master ignores select
// - Rate code picks divisor 2/8/32/128
// - Serial clock is base over twice divisor
// - Rate ignored in slave; reset clears it
// - Data address: write transmit, read receive
// - Receive interrupt enable, reset clears
// - Module enable low is partial reset
module spi_flags (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire spi_flags_pkg::ahb_req_type ahb_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire spi_flags_pkg::spi_pins_type pins_i,
    output logic sclk_o,
    output logic sclk_oe_o,
    output logic mosi_o,
    output logic mosi_oe_o,
    output logic miso_o,
    output logic miso_oe_o,
    output logic ss_gpio_free_o,
    output logic irq_o
);
    import spi_flags_pkg::*;

    function automatic logic [7:0] rate_divisor(input logic [1:0] code);
        case (code)
            2'b00: rate_divisor = RATE_DIV_00;
            2'b01: rate_divisor = RATE_DIV_01;
            2'b10: rate_divisor = RATE_DIV_10;
            default: rate_divisor = RATE_DIV_11;
        endcase
    endfunction

    // Control and configuration
    logic [7:0] ctrl_q;
    logic err_ie_q, fault_en_q;
    logic [1:0] rate_q;
    // Flags
    logic rx_full_q, overrun_q, mode_fault_q, tx_empty_q;
    logic ovr_armed_q, mf_armed_q;
    logic [7:0] tx_buf_q, rx_buf_q;
    // Bus data phase
    logic wr_pend_q;
    logic [7:0] wr_index_q;
    logic [31:0] hrdata_q;
    logic irq_q;
    // Link
    link_state_type state_q;
    logic [7:0] shift_q;
    logic [2:0] bit_cnt_q;
    logic bit_q;
    logic sclk_q;
    logic [7:0] div_cnt_q;
    logic [3:0] pin_meta_q, pin_sync_q;
    logic sclk_prev_q, ss_prev_q;
    logic ss_free_q;
    logic late_sample_q;
    logic master_oe_q, slave_oe_q;

    wire rx_ie = ctrl_q[CTRL_RX_IE_BIT];
    wire master = ctrl_q[CTRL_MASTER_BIT];
    wire enabled = ctrl_q[CTRL_ENABLE_BIT];
    wire tx_ie = ctrl_q[CTRL_TX_IE_BIT];

    // Bus decode
    wire accept = ahb_i.hsel & ahb_i.hready & (ahb_i.htrans == HTRANS_NONSEQ);
    wire [7:0] acc_index = ahb_i.haddr[9:2];
    wire rd_acc = accept & ~ahb_i.hwrite;
    wire rd_ctrl = rd_acc & (acc_index == CTRL_INDEX);
    wire rd_stat = rd_acc & (acc_index == STAT_INDEX);
    wire rd_data = rd_acc & (acc_index == DATA_INDEX);
    wire wr_ctrl = wr_pend_q & (wr_index_q == CTRL_INDEX);
    wire wr_stat = wr_pend_q & (wr_index_q == STAT_INDEX);
    wire wr_data = wr_pend_q & (wr_index_q == DATA_INDEX);
    wire [7:0] wbyte = ahb_i.hwdata[7:0];

    wire [7:0] stat_view = {rx_full_q, err_ie_q, overrun_q, mode_fault_q,
                            tx_empty_q, fault_en_q, rate_q};
    wire [7:0] rd_byte = rd_ctrl ? ctrl_q : rd_stat ? stat_view : rd_data ? rx_buf_q : 8'h00;

    // Synchronised pins: second stage only feeds logic
    wire sclk_s = pin_sync_q[3];
    wire mosi_s = pin_sync_q[2];
    wire miso_s = pin_sync_q[1];
    wire ss_n_s = pin_sync_q[0];
    wire sclk_rise = sclk_s & ~sclk_prev_q;
    wire sclk_fall = ~sclk_s & sclk_prev_q;
    wire ss_rise = ss_n_s & ~ss_prev_q;
    wire slave_sel = enabled & ~master & ~ss_n_s;

    // Master divider: half period of divisor cycles gives base / (2 * divisor)
    wire [7:0] div_now = rate_divisor(rate_q);
    wire half_tick = master & (div_cnt_q == div_now - 8'h01);

    wire m_rise = half_tick & ~sclk_q;
    wire m_fall = half_tick & sclk_q;
    wire edge_rise = master ? m_rise : (slave_sel & sclk_rise);
    wire edge_fall = master ? m_fall : (slave_sel & sclk_fall);
    wire sample_bit = master ? miso_s : mosi_s;
    // Master takes its input one cycle after the rise: the far side answers on
    // the fall and the synchroniser needs two cycles, too slow for divisor 2
    wire take_bit = master ? late_sample_q : edge_rise;

    wire in_idle = (state_q == ST_IDLE);
    // Handoff only while idle; a busy slave keeps the byte buffered
    wire load_now = enabled & in_idle & ~tx_empty_q;
    wire byte_done = (state_q == ST_DONE);
    wire slave_start = in_idle & ~load_now & ~master & edge_rise;

    // Mode fault causes, only while detection is on
    wire fault_slave = enabled & ~master & fault_en_q & ~in_idle & ss_rise;
    wire fault_master = enabled & master & fault_en_q & ~ss_n_s;
    wire fault_set = fault_slave | fault_master;

    // Bus slave
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_pend_q <= 1'b0;
            wr_index_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
        end else begin
            wr_pend_q <= accept & ahb_i.hwrite;
            if (accept) begin
                wr_index_q <= acc_index;
            end
            if (rd_acc) begin
                hrdata_q <= {24'h00_0000, rd_byte};
            end
        end
    end

    // Control and configuration bits
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q <= CTRL_RESET;
            err_ie_q <= STAT_RESET[STAT_ERR_IE_BIT];
            fault_en_q <= STAT_RESET[STAT_FAULT_EN_BIT];
            rate_q <= STAT_RESET[1:0];
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= wbyte & CTRL_WRITE_MASK;
            end
            if (wr_stat) begin
                err_ie_q <= wbyte[STAT_ERR_IE_BIT];
                fault_en_q <= wbyte[STAT_FAULT_EN_BIT];
                rate_q <= wbyte[STAT_RATE_HI_BIT:STAT_RATE_LO_BIT];
            end
        end
    end

    // Buffers and flags; a set in the same cycle as a clear wins
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_full_q <= STAT_RESET[STAT_RX_FULL_BIT];
            overrun_q <= STAT_RESET[STAT_OVERRUN_BIT];
            mode_fault_q <= STAT_RESET[STAT_MODE_FAULT_BIT];
            tx_empty_q <= STAT_RESET[STAT_TX_EMPTY_BIT];
            ovr_armed_q <= 1'b0;
            mf_armed_q <= 1'b0;
            tx_buf_q <= 8'h00;
            rx_buf_q <= 8'h00;
        end else begin
            if (rd_stat && overrun_q) begin
                ovr_armed_q <= 1'b1;
            end
            if (rd_stat && mode_fault_q) begin
                mf_armed_q <= 1'b1;
            end
            if (rd_data) begin
                rx_full_q <= 1'b0;
                if (ovr_armed_q) begin
                    overrun_q <= 1'b0;
                    ovr_armed_q <= 1'b0;
                end
            end
            if (wr_data) begin
                tx_buf_q <= wbyte;
                tx_empty_q <= 1'b0;
                if (mf_armed_q) begin
                    mode_fault_q <= 1'b0;
                    mf_armed_q <= 1'b0;
                end
            end
            if (byte_done) begin
                if (rx_full_q && !rd_data) begin
                    overrun_q <= 1'b1;
                end else begin
                    rx_buf_q <= shift_q;
                    rx_full_q <= 1'b1;
                end
            end
            if (load_now || !enabled) begin
                tx_empty_q <= 1'b1;
            end
            if (fault_set) begin
                mode_fault_q <= 1'b1;
            end
        end
    end

    // Pin synchronisers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_meta_q <= 4'h1;
            pin_sync_q <= 4'h1;
            sclk_prev_q <= 1'b0;
            ss_prev_q <= 1'b1;
        end else begin
            pin_meta_q <= {pins_i.sclk, pins_i.mosi, pins_i.miso, pins_i.ss_n};
            pin_sync_q <= pin_meta_q;
            sclk_prev_q <= sclk_s;
            ss_prev_q <= ss_n_s;
        end
    end

    // Byte shifter; clearing the enable drops any transfer
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
            shift_q <= 8'h00;
            bit_cnt_q <= 3'h0;
            bit_q <= 1'b0;
            sclk_q <= 1'b0;
            div_cnt_q <= 8'h00;
            late_sample_q <= 1'b0;
        end else if (!enabled) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 3'h0;
            sclk_q <= 1'b0;
            div_cnt_q <= 8'h00;
            late_sample_q <= 1'b0;
        end else begin
            div_cnt_q <= (half_tick || in_idle) ? 8'h00 : div_cnt_q + 8'h01;
            late_sample_q <= m_rise & (state_q == ST_SHIFT);
            case (state_q)
                ST_IDLE: begin
                    if (load_now) begin
                        shift_q <= tx_buf_q;
                        if (master) begin
                            state_q <= ST_SHIFT;
                        end
                    end else if (slave_start) begin
                        bit_q <= sample_bit;
                        state_q <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (master && half_tick) begin
                        sclk_q <= ~sclk_q;
                    end
                    if (take_bit) begin
                        bit_q <= sample_bit;
                    end
                    if (edge_fall) begin
                        shift_q <= {shift_q[6:0], bit_q};
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                        if (bit_cnt_q == LAST_BIT) begin
                            state_q <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Pin roles and interrupt
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ss_free_q <= 1'b1;
            irq_q <= 1'b0;
            master_oe_q <= 1'b0;
            slave_oe_q <= 1'b0;
        end else begin
            ss_free_q <= ~enabled | (master & ~fault_en_q);
            master_oe_q <= enabled & master;
            slave_oe_q <= enabled & ~master & ~ss_n_s;
            irq_q <= (rx_full_q & rx_ie) | (tx_empty_q & tx_ie)
                     | (err_ie_q & (overrun_q | mode_fault_q));
        end
    end

    assign hrdata_o = hrdata_q;
    assign hreadyout_o = 1'b1;
    assign hresp_o = HRESP_OKAY;
    assign sclk_o = sclk_q;
    assign sclk_oe_o = master_oe_q;
    assign mosi_o = shift_q[7];
    assign mosi_oe_o = master_oe_q;
    assign miso_o = shift_q[7];
    assign miso_oe_o = slave_oe_q;
    assign ss_gpio_free_o = ss_free_q;
    assign irq_o = irq_q;

    // Assertion helper: cycles since the serial clock last moved in a transfer
    logic [7:0] hold_cnt_q;
    logic sclk_seen_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold_cnt_q <= 8'h00;
            sclk_seen_q <= 1'b0;
        end else begin
            sclk_seen_q <= sclk_q;
            if (state_q != ST_SHIFT) begin
                hold_cnt_q <= 8'h00;
            end else if (sclk_q != sclk_seen_q) begin
                hold_cnt_q <= 8'h01;
            end else begin
                hold_cnt_q <= hold_cnt_q + 8'h01;
            end
        end
    end

    // Checks
    a_rx_full_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        byte_done && !rx_full_q |=> rx_full_q && rx_buf_q == $past(shift_q))
        else $error("receive-full not set on completed byte");
    a_data_read_clr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_data && !byte_done |=> !rx_full_q)
        else $error("data read left receive-full set");
    a_overrun_keeps: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        byte_done && rx_full_q && !rd_data |=> overrun_q && $stable(rx_buf_q))
        else $error("overrun lost old byte or flag");
    a_overrun_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $fell(overrun_q) |-> $past(rd_data) && $past(ovr_armed_q))
        else $error("overrun cleared without status then data read");
    a_fault_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $fell(mode_fault_q) |-> $past(wr_data) && $past(mf_armed_q))
        else $error("mode fault cleared without status read then write");
    a_fault_needs_en: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(mode_fault_q) |-> $past(fault_en_q))
        else $error("mode fault set while detection off");
    a_master_fault: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        enabled && master && fault_en_q && !ss_n_s |=> mode_fault_q)
        else $error("master fault not flagged");
    a_tx_reload: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_data && enabled && in_idle && !master ##1 in_idle |-> ##[0:2] tx_empty_q)
        else $error("idle transmit buffer not emptied in two cycles");
    a_irq_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !rx_ie && !tx_ie && !err_ie_q ##1 !rx_ie && !tx_ie && !err_ie_q |-> !irq_o)
        else $error("interrupt raised with all enables off");
    a_master_rate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        master && state_q == ST_SHIFT && sclk_q != sclk_seen_q
        |-> hold_cnt_q == rate_divisor(rate_q))
        else $error("serial clock half period wrong");
    a_gpio_role: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        enabled && !master ##1 enabled && !master |-> !ss_gpio_free_o)
        else $error("slave select released in slave mode");

    c_byte_done: cover property (@(posedge clk_i) disable iff (!rst_n_i) byte_done);
    c_overrun: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(overrun_q));
    c_fault: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(mode_fault_q));
    c_irq: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(irq_o));
endmodule

`default_nettype wire

// ==== verilog/spi_flags_pkg.sv ====
/*
 * Shared constants and types for the serial port status, flag and data buffer block.
 * Assumes a 32-bit AHB-Lite bus with one slave and word-aligned registers.
 */
package spi_flags_pkg;
    // Register indices, byte address is four times the index
    localparam logic [7:0] CTRL_INDEX = 8'h10;
    localparam logic [7:0] STAT_INDEX = 8'h11;
    localparam logic [7:0] DATA_INDEX = 8'h12;
    localparam logic [31:0] CTRL_ADDR = {22'h0, CTRL_INDEX, 2'b00};
    localparam logic [31:0] STAT_ADDR = {22'h0, STAT_INDEX, 2'b00};
    localparam logic [31:0] DATA_ADDR = {22'h0, DATA_INDEX, 2'b00};

    // Control register fields
    localparam int CTRL_RX_IE_BIT = 7;
    localparam int CTRL_MASTER_BIT = 5;
    localparam int CTRL_ENABLE_BIT = 1;
    localparam int CTRL_TX_IE_BIT = 0;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'ha3;
    localparam logic [7:0] CTRL_RESET = 8'h20;

    // Status and control register fields
    localparam int STAT_RX_FULL_BIT = 7;
    localparam int STAT_ERR_IE_BIT = 6;
    localparam int STAT_OVERRUN_BIT = 5;
    localparam int STAT_MODE_FAULT_BIT = 4;
    localparam int STAT_TX_EMPTY_BIT = 3;
    localparam int STAT_FAULT_EN_BIT = 2;
    localparam int STAT_RATE_HI_BIT = 1;
    localparam int STAT_RATE_LO_BIT = 0;
    localparam logic [7:0] STAT_WRITE_MASK = 8'h47;
    localparam logic [7:0] STAT_RESET = 8'h08;

    // Master divisors per rate code
    localparam logic [7:0] RATE_DIV_00 = 8'h02;
    localparam logic [7:0] RATE_DIV_01 = 8'h08;
    localparam logic [7:0] RATE_DIV_10 = 8'h20;
    localparam logic [7:0] RATE_DIV_11 = 8'h80;

    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam int TX_RELOAD_CYCLES = 2;

    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic HRESP_OKAY = 1'b0;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } ahb_req_type;

    typedef struct packed {
        logic sclk;
        logic mosi;
        logic miso;
        logic ss_n;
    } spi_pins_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_DONE = 2'b11
    } link_state_type;
endpackage
